// [pcd_override.sv]
/*
 Alternate-function override for the port C and port D pads: per-pad
 multiplexers on pull-up, direction, output value and input enable.
 Assumes peripherals sit in the same clock domain and port registers
 live outside; pad inputs are synchronous to i_ref_clk.
*/
`timescale 1ns/10ps
// Functional notes
// - Transmitter enabled: transmit pad is an output carrying serial data.
// - Receiver enabled: receive pad forced input, level routed to receiver.
// - Forced receive pad pull-up follows port bit unless global pull-up disabled.
// - Enabled external interrupt forces its pad input buffer on.
// - Shared pad feeds serial clock and counter 0; sync mode overrides its output value with the clock.
// - Two-wire enabled: override pull-up, direction, value on clock and data pads.
// - Two-wire clock and data inputs pass through spike filters.
// - Low four port C pads and counter-1 pad get no override.
// - Reset pad in use: its direction, data and pin bits read 0.
// - Two-wire enable takes the clock pad away from ordinary port control.
module pcd_override (
   // clock and reset
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_rst,
   // port C general-purpose registers and pads
   input  wire logic [pcd_pkg::PC_W-1:0] i_portc_out,
   input  wire logic [pcd_pkg::PC_W-1:0] i_portc_dir,
   input  wire logic [pcd_pkg::PC_W-1:0] i_portc_pad,
   // port D general-purpose registers and pads
   input  wire logic [pcd_pkg::PD_W-1:0] i_portd_out,
   input  wire logic [pcd_pkg::PD_W-1:0] i_portd_dir,
   input  wire logic [pcd_pkg::PD_W-1:0] i_portd_pad,
   // global controls
   input  wire logic                    i_global_pullup_disable,
   input  wire logic                    i_input_buffer_disable,
   input  wire logic                    i_reset_pin_disable_fuse,
   // serial unit
   input  wire logic                    i_transmitter_enable,
   input  wire logic                    i_tx_data,
   input  wire logic                    i_receiver_enable,
   input  wire logic                    i_sync_mode_select,
   input  wire logic                    i_serial_clock_out,
   // two-wire interface
   input  wire logic                    i_two_wire_enable,
   input  wire logic                    i_tw_clock_drive,
   input  wire logic                    i_tw_data_drive,
   // external interrupt enables
   input  wire logic                    i_ext_irq_zero_enable,
   input  wire logic                    i_ext_irq_one_enable,
   // port C pad controls
   output logic [pcd_pkg::PC_W-1:0]     o_portc_pullup,
   output logic [pcd_pkg::PC_W-1:0]     o_portc_dir,
   output logic [pcd_pkg::PC_W-1:0]     o_portc_value,
   output logic [pcd_pkg::PC_W-1:0]     o_portc_input_en,
   // port D pad controls
   output logic [pcd_pkg::PD_W-1:0]     o_portd_pullup,
   output logic [pcd_pkg::PD_W-1:0]     o_portd_dir,
   output logic [pcd_pkg::PD_W-1:0]     o_portd_value,
   output logic [pcd_pkg::PD_W-1:0]     o_portd_input_en,
   // port C readback of direction, data and pin bits
   output logic [pcd_pkg::PC_W-1:0]     o_portc_dir_rd,
   output logic [pcd_pkg::PC_W-1:0]     o_portc_out_rd,
   output logic [pcd_pkg::PC_W-1:0]     o_portc_pin_rd,
   // peripheral inputs
   output logic                         o_rx_data,
   output logic                         o_serial_ext_clock,
   output logic                         o_counter0_ext_input,
   output logic                         o_counter1_ext_input,
   output logic                         o_ext_irq_zero,
   output logic                         o_ext_irq_one,
   output logic                         o_tw_clock_in,
   output logic                         o_tw_data_in,
   output logic                         o_reset_pin,
   output logic                         o_comparator_pos_input,
   output logic                         o_comparator_neg_input
);
   // override enables and values, one bit per pad
   logic [pcd_pkg::PC_W-1:0] c_pullup_override_enable;
   logic [pcd_pkg::PC_W-1:0] c_pullup_override_value;
   logic [pcd_pkg::PC_W-1:0] c_direction_override_enable;
   logic [pcd_pkg::PC_W-1:0] c_direction_override_value;
   logic [pcd_pkg::PC_W-1:0] c_port_value_override_enable;
   logic [pcd_pkg::PC_W-1:0] c_port_value_override_value;
   logic [pcd_pkg::PC_W-1:0] c_input_enable_override_enable;
   logic [pcd_pkg::PC_W-1:0] c_input_enable_override_value;
   logic [pcd_pkg::PD_W-1:0] d_pullup_override_enable;
   logic [pcd_pkg::PD_W-1:0] d_pullup_override_value;
   logic [pcd_pkg::PD_W-1:0] d_direction_override_enable;
   logic [pcd_pkg::PD_W-1:0] d_direction_override_value;
   logic [pcd_pkg::PD_W-1:0] d_port_value_override_enable;
   logic [pcd_pkg::PD_W-1:0] d_port_value_override_value;
   logic [pcd_pkg::PD_W-1:0] d_input_enable_override_enable;
   logic [pcd_pkg::PD_W-1:0] d_input_enable_override_value;
   logic                     reset_pin_used;
   logic                     pu_allow;

   assign reset_pin_used = ~i_reset_pin_disable_fuse;
   assign pu_allow       = ~i_global_pullup_disable;

   always_comb begin
      c_pullup_override_enable       = '0;
      c_pullup_override_value        = '0;
      c_direction_override_enable    = '0;
      c_direction_override_value     = '0;
      c_port_value_override_enable   = '0;
      c_port_value_override_value    = '0;
      c_input_enable_override_enable = '0;
      c_input_enable_override_value  = '0;
      // reset pad overrides follow the fuse; pc0..pc3 stay plain
      c_pullup_override_enable[pcd_pkg::PC_RST]       = i_reset_pin_disable_fuse;
      c_direction_override_enable[pcd_pkg::PC_RST]    = i_reset_pin_disable_fuse;
      c_input_enable_override_enable[pcd_pkg::PC_RST] = i_reset_pin_disable_fuse;
      // two-wire pads: open-drain, value held 0, direction is the drive
      c_pullup_override_enable[pcd_pkg::PC_SCL]     = i_two_wire_enable;
      c_pullup_override_enable[pcd_pkg::PC_SDA]     = i_two_wire_enable;
      c_pullup_override_value[pcd_pkg::PC_SCL]      = i_portc_out[pcd_pkg::PC_SCL] & pu_allow;
      c_pullup_override_value[pcd_pkg::PC_SDA]      = i_portc_out[pcd_pkg::PC_SDA] & pu_allow;
      c_direction_override_enable[pcd_pkg::PC_SCL]  = i_two_wire_enable;
      c_direction_override_enable[pcd_pkg::PC_SDA]  = i_two_wire_enable;
      c_direction_override_value[pcd_pkg::PC_SCL]   = i_tw_clock_drive;
      c_direction_override_value[pcd_pkg::PC_SDA]   = i_tw_data_drive;
      c_port_value_override_enable[pcd_pkg::PC_SCL] = i_two_wire_enable;
      c_port_value_override_enable[pcd_pkg::PC_SDA] = i_two_wire_enable;
   end

   always_comb begin
      d_pullup_override_enable       = '0;
      d_pullup_override_value        = '0;
      d_direction_override_enable    = '0;
      d_direction_override_value     = '0;
      d_port_value_override_enable   = '0;
      d_port_value_override_value    = '0;
      d_input_enable_override_enable = '0;
      d_input_enable_override_value  = '0;
      // receive pad: forced input, pull-up still from port bit
      d_pullup_override_enable[pcd_pkg::PD_RXD]    = i_receiver_enable;
      d_pullup_override_value[pcd_pkg::PD_RXD]     = i_portd_out[pcd_pkg::PD_RXD] & pu_allow;
      d_direction_override_enable[pcd_pkg::PD_RXD] = i_receiver_enable;
      // transmit pad: forced output carrying serial data
      d_pullup_override_enable[pcd_pkg::PD_TXD]     = i_transmitter_enable;
      d_direction_override_enable[pcd_pkg::PD_TXD]  = i_transmitter_enable;
      d_direction_override_value[pcd_pkg::PD_TXD]   = 1'b1;
      d_port_value_override_enable[pcd_pkg::PD_TXD] = i_transmitter_enable;
      d_port_value_override_value[pcd_pkg::PD_TXD]  = i_tx_data;
      // interrupt pads keep the input buffer alive in sleep
      d_input_enable_override_enable[pcd_pkg::PD_IRQ0] = i_ext_irq_zero_enable;
      d_input_enable_override_value[pcd_pkg::PD_IRQ0]  = 1'b1;
      d_input_enable_override_enable[pcd_pkg::PD_IRQ1] = i_ext_irq_one_enable;
      d_input_enable_override_value[pcd_pkg::PD_IRQ1]  = 1'b1;
      // sync mode puts the serial clock on the shared pad's output value; its direction stays with the port bit
      d_port_value_override_enable[pcd_pkg::PD_XCK] = i_sync_mode_select;
      d_port_value_override_value[pcd_pkg::PD_XCK]  = i_serial_clock_out;
      // counter-1 and comparator pads stay plain
   end

   // per-pad muxes: override when enabled, else port register value; input enable falls back to the global buffer control
   always_comb begin
      for (int i = 0; i < pcd_pkg::PC_W; i++) begin
         o_portc_pullup[i] = c_pullup_override_enable[i] ? c_pullup_override_value[i]
                             : (i_portc_out[i] & ~i_portc_dir[i] & pu_allow);
         o_portc_dir[i]    = c_direction_override_enable[i] ? c_direction_override_value[i]
                             : i_portc_dir[i];
         o_portc_value[i]  = c_port_value_override_enable[i] ? c_port_value_override_value[i]
                             : i_portc_out[i];
         o_portc_input_en[i] = c_input_enable_override_enable[i]
                             ? c_input_enable_override_value[i]
                             : ~i_input_buffer_disable;
      end
      for (int j = 0; j < pcd_pkg::PD_W; j++) begin
         o_portd_pullup[j] = d_pullup_override_enable[j] ? d_pullup_override_value[j]
                             : (i_portd_out[j] & ~i_portd_dir[j] & pu_allow);
         o_portd_dir[j]    = d_direction_override_enable[j] ? d_direction_override_value[j]
                             : i_portd_dir[j];
         o_portd_value[j]  = d_port_value_override_enable[j] ? d_port_value_override_value[j]
                             : i_portd_out[j];
         o_portd_input_en[j] = d_input_enable_override_enable[j]
                             ? d_input_enable_override_value[j]
                             : ~i_input_buffer_disable;
      end
   end

   // reads of the reset pad bits return 0 while it serves as reset
   always_comb begin
      o_portc_dir_rd = i_portc_dir;
      o_portc_out_rd = i_portc_out;
      o_portc_pin_rd = i_portc_pad & o_portc_input_en;
      if (reset_pin_used) begin
         o_portc_dir_rd[pcd_pkg::PC_RST] = 1'b0;
         o_portc_out_rd[pcd_pkg::PC_RST] = 1'b0;
         o_portc_pin_rd[pcd_pkg::PC_RST] = 1'b0;
      end
   end

   // reset pad routed to reset circuit only while fuse unprogrammed
   assign o_reset_pin = reset_pin_used & i_portc_pad[pcd_pkg::PC_RST];

   // usart and counter inputs; the shared pad feeds both consumers
   assign o_rx_data            = i_portd_pad[pcd_pkg::PD_RXD];
   assign o_serial_ext_clock   = i_portd_pad[pcd_pkg::PD_XCK];
   assign o_counter0_ext_input = i_portd_pad[pcd_pkg::PD_XCK];
   assign o_counter1_ext_input = i_portd_pad[pcd_pkg::PD_CNT1];
   // gated by input enable so a disabled buffer reads 0
   assign o_ext_irq_zero = i_portd_pad[pcd_pkg::PD_IRQ0] & o_portd_input_en[pcd_pkg::PD_IRQ0];
   assign o_ext_irq_one  = i_portd_pad[pcd_pkg::PD_IRQ1] & o_portd_input_en[pcd_pkg::PD_IRQ1];
   // analog taps; digital side is left to software setup
   assign o_comparator_pos_input = i_portd_pad[pcd_pkg::PD_CMP_POS];
   assign o_comparator_neg_input = i_portd_pad[pcd_pkg::PD_CMP_NEG];

   // filters add SPIKE_CYC cycles of latency; short glitches never reach the bus logic
   pcd_spike_filter #(
      .CYC (pcd_pkg::SPIKE_CYC)
   ) u_scl_filt (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_raw     (i_portc_pad[pcd_pkg::PC_SCL]),
      .o_filt    (o_tw_clock_in)
   );

   pcd_spike_filter #(
      .CYC (pcd_pkg::SPIKE_CYC)
   ) u_sda_filt (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_raw     (i_portc_pad[pcd_pkg::PC_SDA]),
      .o_filt    (o_tw_data_in)
   );
endmodule

// [pcd_pkg.sv]
/*
 Package for the port C / port D alternate-function override block:
 pad indices, field widths, reset values and spike-filter timing.
 Assumes the core clock runs at 250 MHz.
*/
package pcd_pkg;
   // pad widths
   localparam int PC_W = 7;
   localparam int PD_W = 8;
   // port C pad indices
   localparam int PC_SDA = 4;
   localparam int PC_SCL = 5;
   localparam int PC_RST = 6;
   // port D pad indices
   localparam int PD_RXD = 0;
   localparam int PD_TXD = 1;
   localparam int PD_IRQ0 = 2;
   localparam int PD_IRQ1 = 3;
   localparam int PD_XCK = 4;
   localparam int PD_CNT1 = 5;
   localparam int PD_CMP_POS = 6;
   localparam int PD_CMP_NEG = 7;
   // spike filter: reject pulses shorter than this
   localparam int CLK_PERIOD_PS = 4000;
   localparam int SPIKE_NS = 50;
   localparam int SPIKE_CYC = (SPIKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SPIKE_CNT_W = 4;
   // filter output after reset: released bus reads high
   localparam logic FILT_RST_VAL = 1'b1;
endpackage

// [pcd_spike_filter.sv]
/*
 Spike filter for one two-wire pad input.
 Assumes the input is already synchronous to i_ref_clk.
*/
`timescale 1ns/10ps
module pcd_spike_filter #(
   parameter int unsigned CYC = pcd_pkg::SPIKE_CYC
) (
   // clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_rst,
   // pad level in, filtered level out
   input  wire logic i_raw,
   output logic      o_filt
);
   logic [pcd_pkg::SPIKE_CNT_W-1:0] cnt_q;
   logic [pcd_pkg::SPIKE_CNT_W-1:0] cnt_d;
   logic                            filt_q;
   logic                            filt_d;

   // output changes only after the input has differed for CYC cycles
   always_comb begin
      cnt_d  = '0;
      filt_d = filt_q;
      if (i_raw != filt_q) begin
         if (cnt_q == pcd_pkg::SPIKE_CNT_W'(CYC - 1)) begin
            filt_d = i_raw;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         cnt_q  <= '0;
         filt_q <= pcd_pkg::FILT_RST_VAL;
      end else begin
         cnt_q  <= cnt_d;
         filt_q <= filt_d;
      end
   end

   assign o_filt = filt_q;
endmodule

// [pcd_periph_model.sv]
/*
 Stand-in for the serial unit and two-wire engine beside the pad muxes.
 Assumes the same clock and synchronous reset as the override block.
*/
`timescale 1ns/10ps
module pcd_periph_model (
   input  wire logic i_ref_clk,
   input  wire logic i_rst,
   output logic      o_tx_data,
   output logic      o_serial_clock_out,
   output logic      o_tw_clock_drive,
   output logic      o_tw_data_drive
);
   logic [7:0] lfsr_q;
   logic [7:0] lfsr_d;
   // pseudo-random bit stream: seen at the pads only through the muxes
   always_comb begin
      lfsr_d = i_rst ? 8'hA5 : {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
   end
   always_ff @(posedge i_ref_clk) begin
      lfsr_q <= lfsr_d;
   end
   assign o_tx_data          = lfsr_q[0];
   assign o_serial_clock_out = lfsr_q[1];
   assign o_tw_clock_drive   = lfsr_q[3];
   assign o_tw_data_drive    = lfsr_q[5];
endmodule

// [pcd_override_sva.sv]
/*
 Checker for the pad override muxes and the two-wire input filter.
 Assumes inputs change only between clock edges.
*/
`timescale 1ns/10ps
module pcd_override_sva (
   input wire logic i_ref_clk, i_rst, i_global_pullup_disable, i_reset_pin_disable_fuse,
   input wire logic i_transmitter_enable, i_tx_data, i_receiver_enable, i_sync_mode_select,
   input wire logic i_serial_clock_out, i_two_wire_enable, i_tw_clock_drive, i_tw_data_drive,
   input wire logic i_ext_irq_zero_enable, o_rx_data, o_serial_ext_clock,
   input wire logic o_counter0_ext_input, o_ext_irq_zero, o_tw_clock_in, o_reset_pin,
   input wire logic [pcd_pkg::PC_W-1:0] i_portc_out, i_portc_dir, i_portc_pad, o_portc_dir,
   input wire logic [pcd_pkg::PC_W-1:0] o_portc_value, o_portc_dir_rd, o_portc_out_rd,
   input wire logic [pcd_pkg::PC_W-1:0] o_portc_pin_rd,
   input wire logic [pcd_pkg::PD_W-1:0] i_portd_out, i_portd_pad, o_portd_pullup,
   input wire logic [pcd_pkg::PD_W-1:0] o_portd_dir, o_portd_value, o_portd_input_en
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // edges the clock pad has held its level, saturating
   logic [3:0] stab_q, stab_d;
   logic       pad5_q, pad5_d;
   always_comb begin
      pad5_d = i_portc_pad[5];
      stab_d = (i_rst || i_portc_pad[5] != pad5_q) ? 4'h0 : stab_q + {3'h0, stab_q != 4'hF};
   end
   always_ff @(posedge i_ref_clk) begin
      stab_q <= stab_d;
      pad5_q <= pad5_d;
   end
   chk_tx_pad_out: assert property (i_transmitter_enable |-> o_portd_dir[1]
      && o_portd_value[1] == i_tx_data) else $error("tx pad not driven");
   chk_rx_forced_in: assert property (i_receiver_enable |-> !o_portd_dir[0]
      && o_rx_data == i_portd_pad[0]) else $error("rx pad not input");
   chk_rx_pullup: assert property (i_receiver_enable |-> o_portd_pullup[0] ==
      (i_portd_out[0] && !i_global_pullup_disable)) else $error("rx pull-up wrong");
   chk_irq_buffer_on: assert property (i_ext_irq_zero_enable |-> o_portd_input_en[2]
      && o_ext_irq_zero == i_portd_pad[2]) else $error("irq buffer off");
   chk_xck_shared: assert property (o_serial_ext_clock == i_portd_pad[4] &&
      o_counter0_ext_input == i_portd_pad[4] &&
      (!i_sync_mode_select || o_portd_value[4] == i_serial_clock_out)) else $error("xck pad");
   chk_tw_override: assert property (i_two_wire_enable |-> o_portc_value[5:4] == 2'h0
      && o_portc_dir[5:4] == {i_tw_clock_drive, i_tw_data_drive}) else $error("tw pads");
   // a reset returns the filter to its idle level: that step is not a passed pulse
   chk_filter_reject: assert property (!$past(i_rst) && $changed(o_tw_clock_in) |->
      stab_q >= 4'(pcd_pkg::SPIKE_CYC - 1) && o_tw_clock_in == $past(i_portc_pad[5]))
      else $error("spike passed");
   // stab_q covers edges up to the last one, so compare with the registered pad level
   chk_filter_pass: assert property (stab_q == 4'hF |-> o_tw_clock_in == pad5_q)
      else $error("steady level not passed");
   chk_low_c_plain: assert property (o_portc_dir[3:0] == i_portc_dir[3:0]
      && o_portc_value[3:0] == i_portc_out[3:0]) else $error("low port c overridden");
   chk_reset_pin_rd: assert property (!i_reset_pin_disable_fuse |-> o_reset_pin ==
      i_portc_pad[6] && {o_portc_dir_rd[6], o_portc_out_rd[6], o_portc_pin_rd[6]} == 3'h0)
      else $error("reset pad readback");
endmodule
bind pcd_override pcd_override_sva i_pcd_override_sva (.i_ref_clk, .i_rst,
   .i_global_pullup_disable, .i_reset_pin_disable_fuse, .i_transmitter_enable, .i_tx_data,
   .i_receiver_enable, .i_sync_mode_select, .i_serial_clock_out, .i_two_wire_enable,
   .i_tw_clock_drive, .i_tw_data_drive, .i_ext_irq_zero_enable, .o_rx_data, .o_serial_ext_clock,
   .o_counter0_ext_input, .o_ext_irq_zero, .o_tw_clock_in, .o_reset_pin, .i_portc_out,
   .i_portc_dir, .i_portc_pad, .o_portc_dir, .o_portc_value, .o_portc_dir_rd, .o_portc_out_rd,
   .o_portc_pin_rd, .i_portd_out, .i_portd_pad, .o_portd_pullup, .o_portd_dir, .o_portd_value,
   .o_portd_input_en);

// [pcd_override_tb_top.sv]
/*
 Self-checking bench: random pad and control traffic, filter corners.
 Assumes the design's filter runs with its default length.
*/
`timescale 1ns/10ps
module pcd_override_tb_top;
   logic i_ref_clk = 1'b0, i_rst = 1'b1, i_global_pullup_disable = 1'b0;
   logic i_input_buffer_disable = 1'b0, i_reset_pin_disable_fuse = 1'b0;
   logic i_transmitter_enable = 1'b0, i_receiver_enable = 1'b0, i_sync_mode_select = 1'b0;
   logic i_two_wire_enable = 1'b0, i_ext_irq_zero_enable = 1'b0, i_ext_irq_one_enable = 1'b0;
   logic i_tx_data, i_serial_clock_out, i_tw_clock_drive, i_tw_data_drive;
   logic [6:0] i_portc_out = 7'h00, i_portc_dir = 7'h00, i_portc_pad = 7'h7F;
   logic [7:0] i_portd_out = 8'h00, i_portd_dir = 8'h00, i_portd_pad = 8'h00;
   logic [6:0] o_portc_pullup, o_portc_dir, o_portc_value, o_portc_input_en;
   logic [7:0] o_portd_pullup, o_portd_dir, o_portd_value, o_portd_input_en;
   logic [6:0] o_portc_dir_rd, o_portc_out_rd, o_portc_pin_rd;
   logic o_rx_data, o_serial_ext_clock, o_counter0_ext_input, o_counter1_ext_input;
   logic o_ext_irq_zero, o_ext_irq_one, o_tw_clock_in, o_tw_data_in, o_reset_pin;
   logic o_comparator_pos_input, o_comparator_neg_input;
   int bad_count = 0, n_compared = 0, cyc = 0, seed = 24179;
   logic [27:0] ec;
   logic [31:0] ed;
   pcd_periph_model i_pcd_periph_model (.i_ref_clk, .i_rst, .o_tx_data(i_tx_data),
      .o_serial_clock_out(i_serial_clock_out), .o_tw_clock_drive(i_tw_clock_drive),
      .o_tw_data_drive(i_tw_data_drive));
   pcd_override i_pcd_override (.*);
   initial forever #2 i_ref_clk = ~i_ref_clk;
   task automatic wrap_up();
      if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         wrap_up();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   function automatic logic [31:0] exp_d();
      logic [7:0] pu, dr, vl, ie;
      pu = i_portd_out & ~i_portd_dir & {8{~i_global_pullup_disable}};
      dr = i_portd_dir;
      vl = i_portd_out;
      ie = {8{~i_input_buffer_disable}};
      if (i_transmitter_enable) {pu[1], dr[1], vl[1]} = {2'b01, i_tx_data};
      if (i_receiver_enable) {pu[0], dr[0]} = {i_portd_out[0] & ~i_global_pullup_disable, 1'b0};
      if (i_ext_irq_zero_enable) ie[2] = 1'b1;
      if (i_ext_irq_one_enable) ie[3] = 1'b1;
      if (i_sync_mode_select) vl[4] = i_serial_clock_out;
      return {pu, dr, vl, ie};
   endfunction
   function automatic logic [27:0] exp_c();
      logic [6:0] pu, dr, vl, ie;
      pu = i_portc_out & ~i_portc_dir & {7{~i_global_pullup_disable}};
      dr = i_portc_dir;
      vl = i_portc_out;
      ie = {7{~i_input_buffer_disable}};
      if (i_two_wire_enable) begin
         pu[5:4] = i_portc_out[5:4] & {2{~i_global_pullup_disable}};
         {dr[5:4], vl[5:4]} = {i_tw_clock_drive, i_tw_data_drive, 2'h0};
      end
      if (i_reset_pin_disable_fuse) {pu[6], dr[6], ie[6]} = 3'h0;
      return {pu, dr, vl, ie};
   endfunction
   task automatic step_check();
      logic [6:0] m;
      m = {i_reset_pin_disable_fuse, 6'h3F};
      #2 ec = exp_c();
      ed = exp_d();
      check({o_portd_pullup, o_portd_dir, o_portd_value,
         o_portd_input_en}, ed, "d");
      check(32'({o_portc_pullup, o_portc_dir, o_portc_value,
         o_portc_input_en}), 32'(ec), "c");
      check(32'({o_portc_dir_rd, o_portc_out_rd, o_portc_pin_rd}),
         32'({i_portc_dir & m, i_portc_out & m, i_portc_pad & ec[6:0] & m}), "rd");
      // interrupt one sits above interrupt zero, as pad 3 above pad 2
      check(32'({o_rx_data, o_serial_ext_clock, o_counter0_ext_input,
         o_counter1_ext_input, o_ext_irq_one, o_ext_irq_zero, o_reset_pin,
         o_comparator_pos_input, o_comparator_neg_input}), 32'({i_portd_pad[0],
         {2{i_portd_pad[4]}}, i_portd_pad[5], i_portd_pad[3:2] & ed[3:2],
         ~i_reset_pin_disable_fuse & i_portc_pad[6], i_portd_pad[6], i_portd_pad[7]}), "periph");
   endtask
   initial begin
      repeat (3) @(posedge i_ref_clk);
      #1 i_rst = 1'b0;
      for (int k = 0; k < 2000; k++) begin
         @(posedge i_ref_clk);
         #1 {i_portc_out, i_portc_dir, i_portd_out, i_portd_dir} =
            30'({$random(seed), $random(seed)});
         {i_portd_pad, i_portc_pad[6], i_portc_pad[3:0]} = 13'($random(seed));
         {i_portd_dir[7:6], i_portd_out[7:6]} = 4'h0;
         if (($random(seed) & 31) == 0) i_portc_pad[5:4] = 2'($random(seed));
         {i_global_pullup_disable, i_input_buffer_disable, i_reset_pin_disable_fuse,
            i_transmitter_enable, i_receiver_enable, i_sync_mode_select, i_two_wire_enable,
            i_ext_irq_zero_enable, i_ext_irq_one_enable} = 9'($random(seed));
         step_check();
      end
      // filter corners on both pads: longest rejected pulse, then shortest passed
      for (int b = 4; b < 6; b++) begin
         // realign so the pad never moves on a sampling edge
         @(posedge i_ref_clk);
         #1 i_portc_pad[b] = 1'b1;
         repeat (20) @(posedge i_ref_clk);
         #1 i_portc_pad[b] = 1'b0;
         repeat (12) @(posedge i_ref_clk);
         #1 i_portc_pad[b] = 1'b1;
         #1 check(32'(b == 5 ? o_tw_clock_in : o_tw_data_in), 32'h1, "spike");
         repeat (20) @(posedge i_ref_clk);
         #1 i_portc_pad[b] = 1'b0;
         repeat (12) @(posedge i_ref_clk);
         #1 check(32'(b == 5 ? o_tw_clock_in : o_tw_data_in), 32'h1, "early");
         @(posedge i_ref_clk);
         #1 check(32'(b == 5 ? o_tw_clock_in : o_tw_data_in), 32'h0, "pass");
      end
      i_rst = 1'b1;
      @(posedge i_ref_clk);
      #1 check(32'({o_tw_clock_in, o_tw_data_in}), 32'h3, "reset");
      i_rst = 1'b0;
      repeat (20) @(posedge i_ref_clk);
      #1 check(32'({o_tw_clock_in, o_tw_data_in}), 32'h0, "after reset");
      wrap_up();
   end
endmodule
